// ### verilog/cpu_status_flags_logic.sv
// Condition-register and flag-producing datapath of an 8-bit CPU core.
// Assumes the executor presents one decoded operation per cycle on req_i,
// and raises fast-service entry/return strobes as one-cycle pulses.
// Notes on behaviour
// - Carry is the top condition bit, set on carry out or borrow into bit 7.
// - Shifts and rotates load carry with the last bit shifted out.
// - Dedicated ops set, clear or invert carry, leaving other bits alone.
// - Zero bit set when an arithmetic, logic, test, shift or rotate result is zero.
// - Sign bit copies the result MSB after arithmetic, logic, shift, rotate.
// - Overflow set when a signed result leaves the -128..+127 range.
// - Overflow cleared after every logic operation.
// - Decimal bit records add or subtract last; never a jump condition.
// - Half-carry set on carry out of bit 3 or borrow out of bit 4.
// - Decimal correct uses half-carry and op-type bit to make packed BCD.
// - Fast-service bit set on fast entry, cleared by the service return.
// - Fast-service bit inhibits interrupts; next return takes the fast path.
// - Group select bit picks bank 0 or 1; low op clears, high op sets.
// - Only carry, zero, sign, overflow feed conditional jump evaluation.
// - Direct register writes allowed; collision with flag update stores the AND of the write data and the new flags.
// - AND, OR, XOR, ADD, SUB all update the condition register.
// - Registers addressed by 8-bit address or 4-bit working number.
// - Two paired registers combine into one 16-bit value.
// - Bits numbered 7 down to 0; any bit settable, clearable, invertible, testable.
// - Word increment and decrement act on two-byte operands at once.
// - Fast entry saves flags to a shadow; fast return restores them.
`timescale 1ns/1ps
`include "flags_defines.svh"

module cpu_status_flags_logic (
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    input  wire flags_pkg::alu_req_t req_i,
    input  wire logic              reg_wr_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic [3:0]        work_num_i,
    input  wire logic [4:0]        work_base_i,
    input  wire logic [7:0]        pair_hi_i,
    input  wire logic [7:0]        pair_lo_i,
    input  wire logic              fast_entry_i,
    input  wire logic              return_from_service_op_i,
    input  wire logic [3:0]        cond_code_i,
    output flags_pkg::alu_rsp_t    rsp_o,
    output logic [7:0]             cond_reg_o,
    output logic [7:0]             reg_sel_o,
    output logic [15:0]            pair_word_o,
    output logic                   cond_true_o,
    output logic                   int_inhibit_o,
    output logic                   fast_return_o
);
    import flags_pkg::*;

    // --------------------------------------------------------------
    // Combinational operation result and flag outcome
    // --------------------------------------------------------------
    logic [7:0]  cpu_condition_register;
    logic [7:0]  shadow;
    logic [7:0]  next_flags;
    logic [7:0]  res;
    logic [15:0] wres;
    logic        wr_res;
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [7:0]  da_adj;
    logic        da_carry;
    logic        cin;

    // Evaluate one operation and its flag effects
    always_comb begin
        next_flags = cpu_condition_register;
        res        = req_i.dst;
        wres       = req_i.word;
        wr_res     = 1'b0;
        sum9       = 9'h000;
        nib5       = 5'h00;
        da_adj     = 8'h00;
        da_carry   = 1'b0;
        cin        = cpu_condition_register[`FLAG_CARRY];
        case (req_i.op)
            OP_ADD, OP_ADC: begin
                sum9 = {1'b0, req_i.dst} + {1'b0, req_i.src}
                     + {8'h00, (req_i.op == OP_ADC) & cin};
                nib5 = {1'b0, req_i.dst[3:0]} + {1'b0, req_i.src[3:0]}
                     + {4'h0, (req_i.op == OP_ADC) & cin};
                res = sum9[7:0];
                wr_res = 1'b1;
                next_flags[`FLAG_CARRY] = sum9[8];
                next_flags[`FLAG_OVFL]  = (req_i.dst[7] == req_i.src[7])
                                        & (res[7] != req_i.dst[7]);
                next_flags[`FLAG_DEC]   = 1'b0;
                next_flags[`FLAG_HALF]  = nib5[4];
            end
            OP_SUB, OP_SBC, OP_CP: begin
                sum9 = {1'b0, req_i.dst} - {1'b0, req_i.src}
                     - {8'h00, (req_i.op == OP_SBC) & cin};
                nib5 = {1'b0, req_i.dst[3:0]} - {1'b0, req_i.src[3:0]}
                     - {4'h0, (req_i.op == OP_SBC) & cin};
                res = sum9[7:0];
                wr_res = (req_i.op != OP_CP);
                next_flags[`FLAG_CARRY] = sum9[8];
                next_flags[`FLAG_OVFL]  = (req_i.dst[7] != req_i.src[7])
                                        & (res[7] != req_i.dst[7]);
                next_flags[`FLAG_DEC]   = 1'b1;
                next_flags[`FLAG_HALF]  = nib5[4];
            end
            OP_INC, OP_DEC: begin
                res = (req_i.op == OP_INC) ? req_i.dst + 8'h01 : req_i.dst - 8'h01;
                wr_res = 1'b1;
                next_flags[`FLAG_OVFL] = (req_i.op == OP_INC) ? (req_i.dst == 8'h7f)
                                                              : (req_i.dst == 8'h80);
            end
            OP_AND, OP_OR, OP_XOR, OP_COM, OP_TM, OP_TCM: begin
                case (req_i.op)
                    OP_AND:  res = req_i.dst & req_i.src;
                    OP_OR:   res = req_i.dst | req_i.src;
                    OP_XOR:  res = req_i.dst ^ req_i.src;
                    OP_COM:  res = ~req_i.dst;
                    OP_TM:   res = req_i.dst & req_i.src;
                    default: res = ~req_i.dst & req_i.src;
                endcase
                wr_res = (req_i.op != OP_TM) && (req_i.op != OP_TCM);
                next_flags[`FLAG_OVFL] = 1'b0;
            end
            OP_RL, OP_RLC: begin
                res = {req_i.dst[6:0], (req_i.op == OP_RLC) ? cin : req_i.dst[7]};
                wr_res = 1'b1;
                next_flags[`FLAG_CARRY] = req_i.dst[7];
                next_flags[`FLAG_OVFL]  = res[7] ^ req_i.dst[7];
            end
            OP_RR, OP_RRC, OP_SRA: begin
                case (req_i.op)
                    OP_RR:   res = {req_i.dst[0], req_i.dst[7:1]};
                    OP_RRC:  res = {cin, req_i.dst[7:1]};
                    default: res = {req_i.dst[7], req_i.dst[7:1]};
                endcase
                wr_res = 1'b1;
                next_flags[`FLAG_CARRY] = req_i.dst[0];
                next_flags[`FLAG_OVFL]  = (req_i.op == OP_SRA) ? 1'b0
                                        : res[7] ^ req_i.dst[7];
            end
            OP_DECIMAL_CORRECT: begin
                // Correct the previous binary add or subtract into packed BCD
                if (cpu_condition_register[`FLAG_HALF] || (req_i.dst[3:0] > 4'h9)
                    && !cpu_condition_register[`FLAG_DEC])
                    da_adj[3:0] = 4'h6;
                if (cin || (req_i.dst > 8'h99) && !cpu_condition_register[`FLAG_DEC]) begin
                    da_adj[7:4] = 4'h6;
                    da_carry    = 1'b1;
                end
                res = cpu_condition_register[`FLAG_DEC] ? req_i.dst - da_adj
                                                        : req_i.dst + da_adj;
                wr_res = 1'b1;
                next_flags[`FLAG_CARRY] = da_carry;
            end
            OP_CARRY_SET:    next_flags[`FLAG_CARRY] = 1'b1;
            OP_CARRY_CLEAR:  next_flags[`FLAG_CARRY] = 1'b0;
            OP_CARRY_INVERT: next_flags[`FLAG_CARRY] = ~cin;
            OP_SELECT_LOW:   next_flags[`FLAG_BANK]  = 1'b0;
            OP_SELECT_HIGH:  next_flags[`FLAG_BANK]  = 1'b1;
            OP_WORD_INC: begin
                wres = req_i.word + 16'h0001;
                next_flags[`FLAG_OVFL] = (req_i.word == 16'h7fff);
            end
            OP_WORD_DEC: begin
                wres = req_i.word - 16'h0001;
                next_flags[`FLAG_OVFL] = (req_i.word == 16'h8000);
            end
            OP_BITSET: begin
                res = req_i.dst | (8'h01 << req_i.bit_sel);
                wr_res = 1'b1;
            end
            OP_BITCLR: begin
                res = req_i.dst & ~(8'h01 << req_i.bit_sel);
                wr_res = 1'b1;
            end
            OP_BITINV: begin
                res = req_i.dst ^ (8'h01 << req_i.bit_sel);
                wr_res = 1'b1;
            end
            OP_BITTST: begin
                res = req_i.dst & (8'h01 << req_i.bit_sel);
            end
            default: begin
                res = req_i.dst;
            end
        endcase
        // Zero and sign follow every result-producing operation except bit set, clear and invert; bit test updates zero only
        case (req_i.op)
            OP_NONE, OP_CARRY_SET, OP_CARRY_CLEAR, OP_CARRY_INVERT, OP_SELECT_LOW,
            OP_SELECT_HIGH, OP_BITSET, OP_BITCLR, OP_BITINV: begin
            end
            OP_WORD_INC, OP_WORD_DEC: begin
                next_flags[`FLAG_ZERO] = (wres == 16'h0000);
                next_flags[`FLAG_SIGN] = wres[15];
            end
            OP_BITTST: next_flags[`FLAG_ZERO] = (res == 8'h00);
            default: begin
                next_flags[`FLAG_ZERO] = (res == 8'h00);
                next_flags[`FLAG_SIGN] = res[7];
            end
        endcase
        if (!req_i.valid)
            next_flags = cpu_condition_register;
    end

    // --------------------------------------------------------------
    // Condition register, shadow and fast-service sequencing
    // --------------------------------------------------------------
    logic fast_ret_take;
    assign fast_ret_take = return_from_service_op_i
                         & cpu_condition_register[`FLAG_FAST];

    // Flag register update: fast entry, fast return, direct write (ANDed with any op result), op result
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_condition_register <= `COND_REG_RESET;
        end else if (fast_entry_i) begin
            cpu_condition_register[`FLAG_FAST] <= 1'b1;
        end else if (fast_ret_take) begin
            cpu_condition_register <= {shadow[7:2], 1'b0, shadow[0]};
        end else if (reg_wr_i && reg_addr_i == `COND_REG_ADDR && req_i.valid) begin
            cpu_condition_register <= next_flags & reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == `COND_REG_ADDR) begin
            cpu_condition_register <= reg_wdata_i;
        end else begin
            cpu_condition_register <= next_flags;
        end
    end

    // Shadow copy of the flags taken at fast entry
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i)
            shadow <= `COND_REG_RESET;
        else if (fast_entry_i)
            shadow <= cpu_condition_register;
    end

    // Result register toward the register file
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.valid  <= req_i.valid & wr_res;
            rsp_o.result <= res;
            rsp_o.word   <= wres;
        end
    end

    // --------------------------------------------------------------
    // Addressing and condition evaluation
    // --------------------------------------------------------------
    assign reg_sel_o     = (reg_addr_i[7:4] == 4'hc) ? {work_base_i[4:1], work_num_i}
                                                     : reg_addr_i;
    assign pair_word_o   = {pair_hi_i, pair_lo_i};
    assign cond_reg_o    = cpu_condition_register;
    assign int_inhibit_o = cpu_condition_register[`FLAG_FAST];
    assign fast_return_o = fast_ret_take;

    logic c_f, z_f, s_f, v_f;
    assign c_f = cpu_condition_register[`FLAG_CARRY];
    assign z_f = cpu_condition_register[`FLAG_ZERO];
    assign s_f = cpu_condition_register[`FLAG_SIGN];
    assign v_f = cpu_condition_register[`FLAG_OVFL];

    // Jump condition from the four upper flags only
    always_comb begin
        case (cond_code_i[2:0])
            3'h0:    cond_true_o = 1'b0;
            3'h1:    cond_true_o = s_f ^ v_f;
            3'h2:    cond_true_o = z_f | (s_f ^ v_f);
            3'h3:    cond_true_o = c_f | z_f;
            3'h4:    cond_true_o = v_f;
            3'h5:    cond_true_o = s_f;
            3'h6:    cond_true_o = z_f;
            default: cond_true_o = c_f;
        endcase
        if (cond_code_i[3])
            cond_true_o = ~cond_true_o;
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    property p_add_carry;
        @(posedge clock_i) disable iff (!rstn_i)
        (req_i.valid && req_i.op == OP_ADD && !fast_entry_i && !fast_ret_take && !reg_wr_i)
        |=> cpu_condition_register[7] == $past(sum9[8]);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("carry wrong after add");

    property p_rot_carry;
        @(posedge clock_i) disable iff (!rstn_i)
        (req_i.valid && req_i.op == OP_RR && !fast_entry_i && !fast_ret_take && !reg_wr_i)
        |=> cpu_condition_register[7] == $past(req_i.dst[0]);
    endproperty
    a_rot_carry: assert property (p_rot_carry) else $error("carry wrong after rotate");

    property p_ccf;
        @(posedge clock_i) disable iff (!rstn_i)
        (req_i.valid && req_i.op == OP_CARRY_INVERT
         && !fast_entry_i && !fast_ret_take && !reg_wr_i)
        |=> cpu_condition_register == ($past(cpu_condition_register) ^ 8'h80);
    endproperty
    a_ccf: assert property (p_ccf) else $error("carry invert disturbed flags");

    property p_zero;
        @(posedge clock_i) disable iff (!rstn_i)
        (req_i.valid && req_i.op == OP_XOR && req_i.dst == req_i.src
         && !fast_entry_i && !fast_ret_take && !reg_wr_i)
        |=> cpu_condition_register[6] && !cpu_condition_register[5];
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag missing");

    property p_logic_ovf;
        @(posedge clock_i) disable iff (!rstn_i)
        (req_i.valid && req_i.op == OP_AND && !fast_entry_i && !fast_ret_take && !reg_wr_i)
        |=> !cpu_condition_register[4];
    endproperty
    a_logic_ovf: assert property (p_logic_ovf) else $error("overflow not cleared");

    property p_sub_dec;
        @(posedge clock_i) disable iff (!rstn_i)
        (req_i.valid && req_i.op == OP_SUB && !fast_entry_i && !fast_ret_take && !reg_wr_i)
        |=> cpu_condition_register[3];
    endproperty
    a_sub_dec: assert property (p_sub_dec) else $error("op-type bit not set");

    property p_fast_inhibit;
        @(posedge clock_i) disable iff (!rstn_i)
        fast_entry_i |=> int_inhibit_o ##1 (int_inhibit_o || $past(fast_ret_take));
    endproperty
    a_fast_inhibit: assert property (p_fast_inhibit) else $error("fast entry not seen");

    property p_fast_restore;
        @(posedge clock_i) disable iff (!rstn_i)
        (fast_ret_take && !fast_entry_i)
        |=> (cpu_condition_register == {$past(shadow[7:2]), 1'b0, $past(shadow[0])});
    endproperty
    a_fast_restore: assert property (p_fast_restore) else $error("shadow not restored");

    property p_bank;
        @(posedge clock_i) disable iff (!rstn_i)
        (req_i.valid && req_i.op == OP_SELECT_HIGH
         && !fast_entry_i && !fast_ret_take && !reg_wr_i)
        |=> cpu_condition_register[0];
    endproperty
    a_bank: assert property (p_bank) else $error("bank bit not set");

endmodule // cpu_status_flags_logic

// ### verilog/flags_defines.svh
// Constants for the CPU condition-register logic: offset, bit positions,
// reset value. Included by the design file and the testbench.
`ifndef FLAGS_DEFINES_SVH
`define FLAGS_DEFINES_SVH
`define COND_REG_ADDR   8'hd5
`define FLAG_CARRY      7
`define FLAG_ZERO       6
`define FLAG_SIGN       5
`define FLAG_OVFL       4
`define FLAG_DEC        3
`define FLAG_HALF       2
`define FLAG_FAST       1
`define FLAG_BANK       0
`define COND_REG_RESET  8'h00
`endif

// ### verilog/flags_pkg.sv
// Types shared by the condition-register logic: operation codes and the
// operation request carrier. Assumes the executor decodes opcodes itself.
package flags_pkg;
    typedef enum logic [4:0] {
        OP_NONE   = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
        OP_SBC    = 5'h04, OP_CP  = 5'h05, OP_AND = 5'h06, OP_OR  = 5'h07,
        OP_XOR    = 5'h08, OP_COM = 5'h09, OP_TM  = 5'h0a, OP_TCM = 5'h0b,
        OP_INC    = 5'h0c, OP_DEC = 5'h0d, OP_RL  = 5'h0e, OP_RLC = 5'h0f,
        OP_RR     = 5'h10, OP_RRC = 5'h11, OP_SRA = 5'h12,
        OP_DECIMAL_CORRECT = 5'h13, OP_CARRY_SET = 5'h14, OP_CARRY_CLEAR = 5'h15,
        OP_CARRY_INVERT = 5'h16, OP_SELECT_LOW = 5'h17, OP_SELECT_HIGH = 5'h18,
        OP_WORD_INC = 5'h19, OP_WORD_DEC = 5'h1a,
        OP_BITSET = 5'h1b, OP_BITCLR = 5'h1c, OP_BITINV = 5'h1d, OP_BITTST = 5'h1e
    } alu_op_t;

    typedef struct packed {
        logic         valid;
        alu_op_t      op;
        logic [7:0]   dst;
        logic [7:0]   src;
        logic [15:0]  word;
        logic [2:0]   bit_sel;
    } alu_req_t;

    typedef struct packed {
        logic         valid;
        logic [7:0]   result;
        logic [15:0]  word;
    } alu_rsp_t;

    typedef enum logic [2:0] {
        SVC_IDLE = 3'b001,
        SVC_FAST = 3'b010,
        SVC_RET  = 3'b100
    } svc_state_t;
endpackage

// ### verif/tb_cpu_status_flags_logic.sv
// Self-checking bench for the condition-register logic.
// Assumes the package and defines header are compiled first; inputs move at falling edges.
`timescale 1ns/1ps
`include "flags_defines.svh"
module tb_cpu_status_flags_logic;
    import flags_pkg::*;
    logic       clock_i, rstn_i, reg_wr_i, fast_entry_i, return_from_service_op_i;
    alu_req_t   req_i;
    alu_rsp_t   rsp_o;
    logic [7:0] reg_addr_i, reg_wdata_i, pair_hi_i, pair_lo_i, cond_reg_o, reg_sel_o;
    logic [3:0] work_num_i, cond_code_i;
    logic [4:0] work_base_i;
    logic [15:0] pair_word_o;
    logic       cond_true_o, int_inhibit_o, fast_return_o;
    int         mismatches, n_checks;

    cpu_status_flags_logic u_cpu_status_flags_logic (.clock_i(clock_i), .rstn_i(rstn_i),
        .req_i(req_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .work_num_i(work_num_i), .work_base_i(work_base_i), .pair_hi_i(pair_hi_i),
        .pair_lo_i(pair_lo_i), .fast_entry_i(fast_entry_i),
        .return_from_service_op_i(return_from_service_op_i), .cond_code_i(cond_code_i),
        .rsp_o(rsp_o), .cond_reg_o(cond_reg_o), .reg_sel_o(reg_sel_o),
        .pair_word_o(pair_word_o), .cond_true_o(cond_true_o), .int_inhibit_o(int_inhibit_o),
        .fast_return_o(fast_return_o));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One operation, taken at the next rising edge; valid stays up for a following op
    task automatic op(input alu_op_t o, input logic [7:0] d, input logic [7:0] s,
                      input logic [15:0] w = 16'h0000, input logic [2:0] b = 3'h0);
        req_i = '{valid: 1'b1, op: o, dst: d, src: s, word: w, bit_sel: b};
        @(negedge clock_i);
    endtask

    // Drop the request and let one edge pass
    task automatic idle;
        req_i.valid = 1'b0;
        @(negedge clock_i);
    endtask

    // Direct register write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask

    // Jump condition expected from the four upper flags only
    function automatic logic cc(input logic [7:0] f, input logic [3:0] k);
        logic c, z, x;
        c = f[7];
        z = f[6];
        x = f[5] ^ f[4];
        case (k)
            4'h0: return 1'b0;   4'h8: return 1'b1;   4'h7: return c;      4'hf: return !c;
            4'h6: return z;      4'he: return !z;     4'h5: return f[5];   4'hd: return !f[5];
            4'h4: return f[4];   4'hc: return !f[4];  4'h1: return x;      4'h9: return !x;
            4'h2: return z | x;  4'ha: return !(z | x);  4'h3: return c | z;
            default: return !c && !z;
        endcase
    endfunction

    // ----------------------------------------
    // Clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // Cut a hang short
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end

    initial begin
        rstn_i = 1'b0; reg_wr_i = 1'b0; fast_entry_i = 1'b0; return_from_service_op_i = 1'b0;
        req_i = '0; reg_addr_i = 8'h00; reg_wdata_i = 8'h00; work_num_i = 4'h0;
        work_base_i = 5'h00; pair_hi_i = 8'h00; pair_lo_i = 8'h00; cond_code_i = 4'h0;
        repeat (8) @(negedge clock_i);
        rstn_i = 1'b1;
        chk(cond_reg_o, 8'h00);
        op(OP_ADD, 8'h7f, 8'h01); chk(rsp_o.result, 8'h80); chk(cond_reg_o, 8'h34);
        op(OP_AND, 8'h80, 8'hff); chk(cond_reg_o, 8'h24);
        op(OP_ADD, 8'hff, 8'h01); chk(cond_reg_o, 8'hc4);
        op(OP_SUB, 8'h00, 8'h01); chk(rsp_o.result, 8'hff); chk(cond_reg_o, 8'hac);
        op(OP_XOR, 8'h5a, 8'h5a); chk(cond_reg_o & 8'h70, 8'h40);
        op(OP_OR, 8'h00, 8'h00); chk(cond_reg_o & 8'h70, 8'h40);
        op(OP_XOR, 8'hf0, 8'h0f); chk(cond_reg_o & 8'h70, 8'h20);
        op(OP_CARRY_CLEAR, 8'h00, 8'h00); chk(cond_reg_o, 8'h2c);
        op(OP_CARRY_SET, 8'h00, 8'h00); chk(cond_reg_o, 8'hac);
        op(OP_CARRY_INVERT, 8'h00, 8'h00); chk(cond_reg_o, 8'h2c);
        op(OP_RL, 8'h80, 8'h00); chk(rsp_o.result, 8'h01); chk(cond_reg_o & 8'he0, 8'h80);
        op(OP_RR, 8'h01, 8'h00); chk(rsp_o.result, 8'h80); chk(cond_reg_o & 8'he0, 8'ha0);
        op(OP_SRA, 8'h01, 8'h00); chk(cond_reg_o & 8'he0, 8'hc0);
        op(OP_RRC, 8'h00, 8'h00); chk(rsp_o.result, 8'h80); chk(cond_reg_o & 8'he0, 8'h20);
        op(OP_ADD, 8'h15, 8'h27); op(OP_DECIMAL_CORRECT, 8'h3c, 8'h00);
        chk(rsp_o.result, 8'h42);
        op(OP_SUB, 8'h42, 8'h15); chk(cond_reg_o & 8'h0c, 8'h0c);
        op(OP_DECIMAL_CORRECT, 8'h2d, 8'h00); chk(rsp_o.result, 8'h27);
        op(OP_SELECT_HIGH, 8'h00, 8'h00); chk(cond_reg_o[0], 1'b1);
        op(OP_SELECT_LOW, 8'h00, 8'h00); chk(cond_reg_o[0], 1'b0);
        op(OP_BITSET, 8'h00, 8'h00, 16'h0000, 3'h3); chk(rsp_o.result, 8'h08);
        op(OP_BITCLR, 8'hff, 8'h00, 16'h0000, 3'h7); chk(rsp_o.result, 8'h7f);
        op(OP_BITINV, 8'h01, 8'h00, 16'h0000, 3'h0); chk(rsp_o.result, 8'h00);
        op(OP_WORD_INC, 8'h00, 8'h00, 16'h00ff); chk(rsp_o.word, 16'h0100);
        op(OP_WORD_DEC, 8'h00, 8'h00, 16'h0000); chk(rsp_o.word, 16'hffff);
        // Carry-in arithmetic, compare, increment, complement, tests, rotate through carry
        op(OP_CARRY_SET, 8'h00, 8'h00); op(OP_ADC, 8'h38, 8'h08);
        chk(rsp_o.valid, 1'b1); chk(rsp_o.result, 8'h41); chk(cond_reg_o, 8'h04);
        op(OP_CARRY_SET, 8'h00, 8'h00); op(OP_SBC, 8'h50, 8'h20);
        chk(rsp_o.result, 8'h2f); chk(cond_reg_o, 8'h0c);
        op(OP_CP, 8'h33, 8'h33); chk(rsp_o.valid, 1'b0); chk(cond_reg_o, 8'h48);
        op(OP_INC, 8'h7f, 8'h00); chk(rsp_o.result, 8'h80); chk(cond_reg_o, 8'h38);
        op(OP_DEC, 8'h80, 8'h00); chk(rsp_o.result, 8'h7f); chk(cond_reg_o, 8'h18);
        op(OP_COM, 8'h0f, 8'h00); chk(rsp_o.result, 8'hf0); chk(cond_reg_o, 8'h28);
        op(OP_TM, 8'hf0, 8'h0f); chk(rsp_o.valid, 1'b0); chk(cond_reg_o, 8'h48);
        op(OP_TCM, 8'hf0, 8'h0f); chk(rsp_o.valid, 1'b0); chk(cond_reg_o, 8'h08);
        op(OP_RLC, 8'h40, 8'h00); chk(rsp_o.result, 8'h80); chk(cond_reg_o, 8'h38);
        idle();
        // Register selection and pairing
        reg_addr_i = 8'h23; pair_hi_i = 8'h9a; pair_lo_i = 8'h5c; @(negedge clock_i);
        chk(reg_sel_o, 8'h23); chk(pair_word_o, 16'h9a5c);
        reg_addr_i = 8'hc5; work_num_i = 4'h5; work_base_i = 5'h15; @(negedge clock_i);
        chk(reg_sel_o, 8'ha5);
        // Jump conditions over every code, with carry and overflow set, then with zero and the four lower flags set
        for (int i = 0; i < 2; i++) begin
            wr(`COND_REG_ADDR, i == 0 ? 8'h90 : 8'h4f);
            chk(cond_reg_o, i == 0 ? 8'h90 : 8'h4f);
            for (int k = 0; k < 16; k++) begin
                cond_code_i = 4'(k);
                @(negedge clock_i);
                chk(cond_true_o, cc(cond_reg_o, 4'(k)));
            end
        end
        // Fast service entry, flag change inside, fast return restores
        wr(`COND_REG_ADDR, 8'h80); chk(int_inhibit_o, 1'b0);
        fast_entry_i = 1'b1; @(negedge clock_i); fast_entry_i = 1'b0;
        chk(cond_reg_o[1], 1'b1); chk(int_inhibit_o, 1'b1);
        op(OP_CARRY_CLEAR, 8'h00, 8'h00); chk(cond_reg_o, 8'h02);
        idle();
        return_from_service_op_i = 1'b1; #1; chk(fast_return_o, 1'b1);
        @(negedge clock_i);
        chk(cond_reg_o, 8'h80); chk(int_inhibit_o, 1'b0);
        #1; chk(fast_return_o, 1'b0);
        @(negedge clock_i); return_from_service_op_i = 1'b0;
        wrap_up();
    end
endmodule // tb_cpu_status_flags_logic
